// [hdl/qcs_device.sv]
// device end: overlapped and queued command logic
// Contract
// - bus release clears both drq and bsy
// - host masks nien before switching device
// - overlap only nop-01, c7, a2, cc
// - queued command completes now or later
// - non-queued command with queue aborts all
// - unique tag kept and restored by service
// - duplicate tag aborts whole queue
// - any queued error aborts queue
// - ready while idle sets serv, pending, intrq
// - serv holds until all ready serviced
// - status read or command clears pending
// - ready while busy sets only serv
// - new command keeps serv, no extra interrupt
// - host masks nien before queuing command
// - host checks serv at every completion
// - queue depth reported as identify word 73
// - serv set when released command ready
// - host avoids command write while drq
`timescale 1ns/1ps
`default_nettype none
module qcs_device #(
    parameter int DEPTH = qcs_pkg::QDEPTH // queue slots
) (
    input wire logic aclk,          // 40 mhz clock
    input wire logic aresetn,       // sync reset, low
    qcs_if.dev bus,                 // ata-side registers
    input wire logic media_ready,   // media ready now for new queued cmd
    input wire logic svc_ready,     // a released command became ready
    input wire logic [7:0] svc_tag, // tag of the ready command
    input wire logic media_err,     // error during queued operation
    input wire logic xfer_done,     // current data phase finished
    output logic [15:0] id_word73   // identify word 73 value
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum {QCS_IDLE, QCS_XFER} qcs_st_t;
    qcs_st_t st_q;                       // bus phase
    logic [DEPTH-1:0] valid_q;           // slot in use
    logic [DEPTH-1:0] rdy_q;             // slot ready for service
    logic [7:0] tagm_q [DEPTH];          // stored tags
    logic [7:0] status_q;                // status register
    logic [7:0] error_q;                 // error register
    logic [7:0] tag_out_q;               // restored tag
    logic pend_q;                        // pending interrupt

    // true for commands that may be overlapped
    function automatic logic is_ovl(input logic [7:0] c, input logic [7:0] f);
        is_ovl = (c == qcs_pkg::OP_RD_QUEUED) || (c == qcs_pkg::OP_WR_QUEUED)
            || (c == qcs_pkg::OP_SERVICE)
            || (c == qcs_pkg::OP_NOP && f == qcs_pkg::NOP_SUB_OVL);
    endfunction

    // ------------------------------------------------------------------
    // decode of an incoming command
    // ------------------------------------------------------------------
    logic is_q;       // queued data command
    logic dup;        // tag already held
    logic qne;        // queue not empty
    logic bad;        // command to abort
    logic [DEPTH-1:0] hit; // slot holding tag
    logic [DEPTH-1:0] shit; // slot holding service tag
    logic any_rdy;    // some slot ready
    logic free_ok;    // a free slot exists
    int free_i;       // first free slot
    int rdy_i;        // first ready slot
    // scan down so the lowest index wins
    // free_ok low means the queue is full
    always_comb begin
        free_i = 0;
        rdy_i = 0;
        free_ok = 1'b0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (!valid_q[i]) begin
                free_i = i;
                free_ok = 1'b1;
            end
            if (rdy_q[i]) begin
                rdy_i = i;
            end
        end
    end
    // one tag compare per slot and source
    for (genvar g = 0; g < DEPTH; g++) begin : g_cmp
        assign hit[g] = valid_q[g] && (tagm_q[g] == bus.tag);
        assign shit[g] = valid_q[g] && (tagm_q[g] == svc_tag);
    end
    assign is_q = (bus.cmd == qcs_pkg::OP_RD_QUEUED)
        || (bus.cmd == qcs_pkg::OP_WR_QUEUED);
    assign qne = |valid_q;
    assign any_rdy = |rdy_q;
    assign dup = is_q && (|hit);
    // a full queue is refused, never overwritten
    assign bad = (!is_ovl(bus.cmd, bus.feat) && qne)
        || dup || (is_q && !free_ok && !media_ready)
        || (bus.cmd == qcs_pkg::OP_SERVICE && !any_rdy);
    wire logic busy = status_q[qcs_pkg::ST_BSY] || status_q[qcs_pkg::ST_DRQ];
    wire logic cmd_go = bus.cmd_wr && bus.sel;
    wire logic abort_all = (cmd_go && bad) || (media_err && qne);

    // ------------------------------------------------------------------
    // queue slots and ready-for-service record
    // ------------------------------------------------------------------
    // abort beats every other update, so no
    // slot is left half removed
    always_ff @(posedge aclk) begin
        if (!aresetn || abort_all) begin
            valid_q <= '0;
            rdy_q <= '0;
        end else begin
            if (cmd_go && is_q && !media_ready) begin
                valid_q[free_i] <= 1'b1;
                tagm_q[free_i] <= bus.tag;
            end
            if (svc_ready) begin
                rdy_q <= rdy_q | shit;
            end
            if (cmd_go && bus.cmd == qcs_pkg::OP_SERVICE && any_rdy) begin
                rdy_q[rdy_i] <= 1'b0;
                valid_q[rdy_i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // bus phase: transfer asserts drq, completion releases the bus
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= QCS_IDLE;
        end else begin
            case (st_q)
                QCS_IDLE: begin
                    if (cmd_go && !bad && (bus.cmd == qcs_pkg::OP_SERVICE
                        || (is_q && media_ready))) begin
                        // data phase from next cycle
                        st_q <= QCS_XFER;
                    end
                end
                QCS_XFER: begin
                    if (xfer_done || abort_all) begin
                        st_q <= QCS_IDLE;
                    end
                end
                default: st_q <= QCS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // status, error and restored tag
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_q <= 8'h01;
            tag_out_q <= qcs_pkg::SECCNT_RST;
        end else if (abort_all) begin
            error_q <= qcs_pkg::ERR_ABORT;
        end else if (cmd_go) begin
            error_q <= 8'h00; // cleared by next command
            if (bus.cmd == qcs_pkg::OP_SERVICE) begin
                tag_out_q <= tagm_q[rdy_i];
            end
        end
    end
    // bsy never rises: every command here
    // moves its data under drq alone
    always_comb begin
        status_q = 8'h00;
        status_q[qcs_pkg::ST_RDY] = 1'b1;
        status_q[qcs_pkg::ST_DRQ] = (st_q == QCS_XFER);
        status_q[qcs_pkg::ST_BSY] = 1'b0; // released: both low
        status_q[qcs_pkg::ST_SERV] = any_rdy;
        status_q[qcs_pkg::ST_ERR] = (error_q == qcs_pkg::ERR_ABORT);
    end

    // ------------------------------------------------------------------
    // pending interrupt: raised by completion or by a new service need
    // while the bus is free and serv is not already set
    // ------------------------------------------------------------------
    wire logic new_rdy = svc_ready && (|(shit & ~rdy_q));
    wire logic done = (st_q == QCS_XFER) && xfer_done;
    wire logic immed = cmd_go && !(st_q == QCS_IDLE && !bad
        && (bus.cmd == qcs_pkg::OP_SERVICE || (is_q && media_ready)));
    // set beats clear, so no completion is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 1'b0;
        end else if (new_rdy && !busy && !any_rdy) begin
            pend_q <= 1'b1;
        end else if (done || immed) begin
            pend_q <= 1'b1;
        end else if (bus.stat_rd || bus.cmd_wr) begin
            pend_q <= 1'b0;
        end
    end

    assign bus.status = status_q;
    assign bus.error = error_q;
    assign bus.tag_out = tag_out_q;
    assign bus.intrq = pend_q && bus.sel && !bus.nien;
    assign id_word73 = 16'(DEPTH - 1);
endmodule : qcs_device
`default_nettype wire

// [hdl/qcs_host.sv]
// host end: axi4-lite driven issuer of queued commands
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module qcs_host (
    input wire logic aclk,           // 40 mhz clock
    input wire logic aresetn,        // sync reset, low
    qcs_if.host bus,                 // ata-side registers
    input wire logic [7:0] awaddr,   // write address
    input wire logic awvalid,        // write address valid
    output logic awready,            // write address ready
    input wire logic [31:0] wdata,   // write data
    input wire logic [3:0] wstrb,    // write strobes
    input wire logic wvalid,         // write data valid
    output logic wready,             // write data ready
    output logic [1:0] bresp,        // write response
    output logic bvalid,             // write response valid
    input wire logic bready,         // write response ready
    input wire logic [7:0] araddr,   // read address
    input wire logic arvalid,        // read address valid
    output logic arready,            // read address ready
    output logic [31:0] rdata,       // read data
    output logic [1:0] rresp,        // read response
    output logic rvalid,             // read valid
    input wire logic rready,         // read ready
    output logic irq                 // level interrupt
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic aw_q, w_q;                 // captured halves
    logic [7:0] awa_q;               // held address
    logic [31:0] wd_q;               // held data
    logic nien_q, sel_q;             // control bits
    logic [7:0] cmd_q, feat_q, tag_q; // command fields
    logic cmdwr_q, strd_q;           // one-cycle strobes
    logic [7:0] st_q, tg_q;          // captured status and tag
    logic [qcs_pkg::IRQ_EVENTS-1:0] ist_q, imask_q; // events, mask
    logic intrq_d1_q;                // previous intrq
    // ------------------------------------------------------------------
    // write channel: both halves in either order, then respond
    // ------------------------------------------------------------------
    assign awready = !aw_q && !bvalid;
    assign wready = !w_q && !bvalid;
    wire logic wgo = aw_q && w_q && !bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= qcs_pkg::RESP_OK;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
        end else begin
            if (awvalid && awready) begin
                aw_q <= 1'b1;
                awa_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_q <= 1'b1;
                wd_q <= wdata;
            end
            if (wgo) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (awa_q == qcs_pkg::A_CTRL || awa_q == qcs_pkg::A_ISTAT
                    || awa_q == qcs_pkg::A_IMASK) ? qcs_pkg::RESP_OK
                    : qcs_pkg::RESP_ERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------------
    // control register: bits 7:0 cmd, 15:8 feat, 23:16 tag, 24 nien,
    // 25 sel, 26 issue command, 27 read status
    // ------------------------------------------------------------------
    logic [3:0] wstrb_q; // held strobes
    wire logic ctl_wr = wgo && awa_q == qcs_pkg::A_CTRL && (&wstrb_q);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wstrb_q <= wstrb;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nien_q <= 1'b1;
            sel_q <= 1'b0;
            cmd_q <= 8'h00;
            feat_q <= 8'h00;
            tag_q <= qcs_pkg::SECCNT_RST;
            cmdwr_q <= 1'b0;
            strd_q <= 1'b0;
        end else begin
            cmdwr_q <= 1'b0;
            strd_q <= 1'b0;
            if (ctl_wr) begin
                cmd_q <= wd_q[7:0];
                feat_q <= wd_q[15:8];
                tag_q <= wd_q[23:16];
                // mask first when switching device
                nien_q <= wd_q[24] || (sel_q != wd_q[25]);
                sel_q <= wd_q[25];
                // no issue while drq
                cmdwr_q <= wd_q[26] && !bus.status[qcs_pkg::ST_DRQ];
                strd_q <= wd_q[27];
                if (wd_q[26]) begin
                    nien_q <= 1'b1;
                end
            end
        end
    end
    assign bus.cmd_wr = cmdwr_q;
    assign bus.cmd = cmd_q;
    assign bus.feat = feat_q;
    assign bus.tag = tag_q;
    assign bus.nien = nien_q;
    assign bus.sel = sel_q;
    assign bus.stat_rd = strd_q;
    // ------------------------------------------------------------------
    // status capture and events: 0 intrq rise, 1 serv seen, 2 error
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= 8'h00;
            tg_q <= 8'h00;
            intrq_d1_q <= 1'b0;
        end else begin
            st_q <= bus.status;
            tg_q <= bus.tag_out;
            intrq_d1_q <= bus.intrq;
        end
    end
    logic [qcs_pkg::IRQ_EVENTS-1:0] ev; // event pulses
    assign ev = {bus.status[qcs_pkg::ST_ERR] && !st_q[qcs_pkg::ST_ERR],
                 bus.status[qcs_pkg::ST_SERV] && !st_q[qcs_pkg::ST_SERV],
                 bus.intrq && !intrq_d1_q};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_q <= '0;
            imask_q <= '0;
        end else begin
            // set wins over write-one-to-clear
            if (wgo && awa_q == qcs_pkg::A_ISTAT) begin
                ist_q <= (ist_q & ~wd_q[qcs_pkg::IRQ_EVENTS-1:0]) | ev;
            end else begin
                ist_q <= ist_q | ev;
            end
            if (wgo && awa_q == qcs_pkg::A_IMASK) begin
                imask_q <= wd_q[qcs_pkg::IRQ_EVENTS-1:0];
            end
        end
    end
    assign irq = |(ist_q & imask_q);
    // ------------------------------------------------------------------
    // read channel: one cycle to rvalid
    // ------------------------------------------------------------------
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= qcs_pkg::RESP_OK;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= qcs_pkg::RESP_OK;
            case (araddr)
                qcs_pkg::A_CTRL: rdata <= {6'h0, sel_q, nien_q, tag_q,
                    feat_q, cmd_q};
                qcs_pkg::A_STAT: rdata <= {24'h0, st_q};
                qcs_pkg::A_TAG: rdata <= {24'h0, tg_q};
                qcs_pkg::A_ISTAT: rdata <= {29'h0, ist_q};
                qcs_pkg::A_IMASK: rdata <= {29'h0, imask_q};
                default: begin
                    rdata <= 32'h0;
                    rresp <= qcs_pkg::RESP_ERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : qcs_host
`default_nettype wire

// [hdl/qcs_if.sv]
// interface joining the queued-command device end and the host end
`timescale 1ns/1ps
`default_nettype none
interface qcs_if;
    logic cmd_wr;      // host writes command register (pulse)
    logic [7:0] cmd;   // command opcode
    logic [7:0] feat;  // feature/subcommand
    logic [7:0] tag;   // sector count, tag for queued commands
    logic nien;        // interrupt disable, held by host
    logic sel;         // device selected by device/head
    logic stat_rd;     // host reads status register (pulse)
    logic [7:0] status; // status register
    logic [7:0] error;  // error register
    logic [7:0] tag_out; // restored tag
    logic intrq;       // interrupt request
    modport dev (input cmd_wr, cmd, feat, tag, nien, sel, stat_rd,
                 output status, error, tag_out, intrq);
    modport host (output cmd_wr, cmd, feat, tag, nien, sel, stat_rd,
                  input status, error, tag_out, intrq);
endinterface : qcs_if
`default_nettype wire

// [hdl/qcs_pkg.sv]
// package of shared constants for the queued command service block
package qcs_pkg;
    // ------------------------------------------------------------------
    // command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_NOP = 8'h00;       // nop, needs subcommand
    localparam logic [7:0] NOP_SUB_OVL = 8'h01;  // overlap-able nop sub
    localparam logic [7:0] OP_RD_QUEUED = 8'hC7; // read dma queued
    localparam logic [7:0] OP_SERVICE = 8'hA2;   // service
    localparam logic [7:0] OP_WR_QUEUED = 8'hCC; // write dma queued
    // ------------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------------
    localparam int ST_ERR = 0;  // error
    localparam int ST_DRQ = 3;  // data request
    localparam int ST_SERV = 4; // service request
    localparam int ST_RDY = 6;  // ready
    localparam int ST_BSY = 7;  // busy
    localparam logic [7:0] ERR_ABORT = 8'h04; // aborted-command error code
    // ------------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------------
    localparam int QDEPTH = 8;                 // default queue depth
    localparam int TAGW = 5;                   // tag width
    localparam int ID_WORD_QDEPTH = 73;        // identify word with depth
    localparam logic [7:0] SECCNT_RST = 8'h01; // sector count after reset
    localparam int IRQ_EVENTS = 3;             // host interrupt events
    // ------------------------------------------------------------------
    // host-side AXI4-Lite register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;   // control/command issue
    localparam logic [7:0] A_STAT = 8'h04;   // last device status
    localparam logic [7:0] A_TAG = 8'h08;    // last tag
    localparam logic [7:0] A_ISTAT = 8'h0C;  // sticky events
    localparam logic [7:0] A_IMASK = 8'h10;  // event mask
    localparam logic [1:0] RESP_OK = 2'h0;   // okay
    localparam logic [1:0] RESP_ERR = 2'h2;  // slverr
endpackage : qcs_pkg

// [test/qcs_assertions.sv]
// concurrent checks on the queued command link
`timescale 1ns/1ps
`default_nettype none
module qcs_assertions (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low
    input wire logic cmd_wr, // command write
    input wire logic stat_rd, // status read
    input wire logic sel, // device selected
    input wire logic nien, // interrupt mask
    input wire logic [7:0] status, // status
    input wire logic [7:0] error, // error code
    input wire logic intrq, // interrupt
    input wire logic svc_ready, // tag ready
    input wire logic media_err, // queued fault
    input wire logic xfer_done // data phase end
);
    // ------------------------------------------------------------
    // properties, one clock, reset disables all
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rel; !status[qcs_pkg::ST_BSY]; endproperty
    a_rel: assert property (p_rel) else $error("busy seen");
    property p_gate; intrq |-> sel && !nien; endproperty
    a_gate: assert property (p_gate) else $error("irq ungated");
    property p_clr; (stat_rd || cmd_wr) && !svc_ready && !xfer_done
        |=> !intrq; endproperty
    a_clr: assert property (p_clr) else $error("irq kept");
    property p_srv; svc_ready && !cmd_wr && !media_err
        |=> status[qcs_pkg::ST_SERV]; endproperty
    a_srv: assert property (p_srv) else $error("serv not set");
    property p_hold; status[qcs_pkg::ST_SERV] && !cmd_wr && !media_err
        && !xfer_done |=> status[qcs_pkg::ST_SERV]; endproperty
    a_hold: assert property (p_hold) else $error("serv dropped");
    property p_drq; status[qcs_pkg::ST_DRQ] && !xfer_done && !media_err
        && !cmd_wr |=> status[qcs_pkg::ST_DRQ]; endproperty
    a_drq: assert property (p_drq) else $error("drq dropped");
    property p_abt; $rose(status[qcs_pkg::ST_ERR])
        |-> $past(cmd_wr) || $past(media_err); endproperty
    a_abt: assert property (p_abt) else $error("err without cause");
    property p_busy; status[qcs_pkg::ST_DRQ] |-> !intrq; endproperty
    a_busy: assert property (p_busy) else $error("irq in data");
    c_srv: cover property ($rose(status[qcs_pkg::ST_SERV]));
    c_drq: cover property ($rose(status[qcs_pkg::ST_DRQ]));
    c_err: cover property ($rose(status[qcs_pkg::ST_ERR]));
endmodule // qcs_assertions
`default_nettype wire

// [test/tb_queued_command_service.sv]
// self-checking bench for both ends of the queued command link
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb_queued_command_service;
    localparam int DEPTH = 4; // small queue keeps runs short
    logic aclk = 1'b0, aresetn = 1'b0; // clock, reset
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, svc_tag = 8'h00; // stimulus
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // write side
    logic arvalid = 1'b0, rready = 1'b0, media_ready = 1'b0; // read side
    logic svc_ready = 1'b0, media_err = 1'b0, xfer_done = 1'b0; // events
    logic [31:0] wdata = 32'h0, rv; // data
    logic [3:0] wstrb = 4'hF; // full words only
    logic awready, wready, bvalid, arready, rvalid, irq, ta, tw;
    logic [1:0] bresp, rresp, resp; // responses
    logic [31:0] rdata; // read data
    logic [15:0] id_word73; // depth word
    int miscompares = 0, checked = 0; // tallies
    qcs_if bus ();
    always #12.5 aclk = ~aclk;
    qcs_device #(.DEPTH(DEPTH)) qcs_device_inst (.aclk(aclk),
        .aresetn(aresetn), .bus(bus), .media_ready(media_ready),
        .svc_ready(svc_ready), .svc_tag(svc_tag), .media_err(media_err),
        .xfer_done(xfer_done), .id_word73(id_word73));
    qcs_host qcs_host_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq(irq));
    qcs_assertions qcs_assertions_inst (.aclk(aclk), .aresetn(aresetn),
        .cmd_wr(bus.cmd_wr), .stat_rd(bus.stat_rd), .sel(bus.sel),
        .nien(bus.nien), .status(bus.status), .error(bus.error),
        .intrq(bus.intrq), .svc_ready(svc_ready), .media_err(media_err),
        .xfer_done(xfer_done));
    // ------------------------------------------------------------
    // bus tasks: ready and valid are sampled at the rising edge
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            ta = awvalid && !awready;
            tw = wvalid && !wready;
            if (!ta) awvalid <= 1'b0;
            if (!tw) wvalid <= 1'b0;
        end while (ta || tw);
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // issue one command with issue, sel and nien set
    task automatic iss(input logic [7:0] c, f, t);
        wr(qcs_pkg::A_CTRL, {5'h00, 3'h7, t, f, c});
        repeat (3) @(posedge aclk);
    endtask
    // one-cycle event on the media side: 0 ready, 1 done, 2 fault
    task automatic pulse(input int k, input logic [7:0] t);
        @(posedge aclk);
        svc_tag <= t;
        svc_ready <= (k == 0);
        xfer_done <= (k == 1);
        media_err <= (k == 2);
        @(posedge aclk);
        svc_ready <= 1'b0;
        xfer_done <= 1'b0;
        media_err <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #2000000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(qcs_pkg::A_STAT);
        `CHK("status", 8'h40, rv[7:0])
        `CHK("depth", 16'(DEPTH - 1), id_word73)
        rd(8'h14);
        `CHK("rresp", qcs_pkg::RESP_ERR, resp)
        $display("reset test done");
        iss(qcs_pkg::OP_RD_QUEUED, 8'h00, 8'h01);
        iss(qcs_pkg::OP_WR_QUEUED, 8'h00, 8'h02);
        rd(qcs_pkg::A_STAT);
        `CHK("status", 8'h40, rv[7:0])
        wr(qcs_pkg::A_CTRL, 32'h0200_0000);
        pulse(0, 8'h01);
        `CHK("intrq", 1'b1, bus.intrq)
        rd(qcs_pkg::A_ISTAT);
        `CHK("istat", 32'h3, rv)
        wr(qcs_pkg::A_IMASK, 32'h0);
        `CHK("irq", 1'b0, irq)
        wr(qcs_pkg::A_IMASK, 32'h7);
        `CHK("irq", 1'b1, irq)
        `CHK("bresp", qcs_pkg::RESP_OK, resp)
        wr(qcs_pkg::A_CTRL, 32'h0A00_0000);
        repeat (2) @(posedge aclk);
        `CHK("intrq", 1'b0, bus.intrq)
        rd(qcs_pkg::A_STAT);
        `CHK("status", 8'h50, rv[7:0])
        wr(qcs_pkg::A_ISTAT, 32'h7);
        repeat (2) @(posedge aclk);
        `CHK("irq", 1'b0, irq)
        $display("release test done");
        iss(qcs_pkg::OP_SERVICE, 8'h00, 8'h00);
        `CHK("drq", 1'b1, bus.status[qcs_pkg::ST_DRQ])
        `CHK("tag", 8'h01, bus.tag_out)
        rd(qcs_pkg::A_TAG);
        `CHK("tag reg", 8'h01, rv[7:0])
        pulse(1, 8'h00);
        `CHK("status", 8'h40, bus.status)
        $display("service test done");
        iss(qcs_pkg::OP_WR_QUEUED, 8'h00, 8'h02);
        `CHK("error", qcs_pkg::ERR_ABORT, bus.error)
        iss(qcs_pkg::OP_RD_QUEUED, 8'h00, 8'h03);
        `CHK("error", 8'h00, bus.error)
        iss(qcs_pkg::OP_NOP, 8'h00, 8'h00);
        `CHK("error", qcs_pkg::ERR_ABORT, bus.error)
        iss(qcs_pkg::OP_NOP, qcs_pkg::NOP_SUB_OVL, 8'h00);
        `CHK("error", 8'h00, bus.error)
        iss(qcs_pkg::OP_RD_QUEUED, 8'h00, 8'h03);
        `CHK("error", 8'h00, bus.error)
        pulse(2, 8'h00);
        `CHK("error", qcs_pkg::ERR_ABORT, bus.error)
        iss(qcs_pkg::OP_RD_QUEUED, 8'h00, 8'h03);
        `CHK("error", 8'h00, bus.error)
        $display("abort test done");
        media_ready <= 1'b1;
        iss(qcs_pkg::OP_WR_QUEUED, 8'h00, 8'h09);
        wr(qcs_pkg::A_CTRL, 32'h0200_0000);
        pulse(0, 8'h03);
        `CHK("status", 8'h58, bus.status)
        `CHK("intrq", 1'b0, bus.intrq)
        pulse(1, 8'h00);
        `CHK("serv", 1'b1, bus.status[qcs_pkg::ST_SERV])
        $display("busy test done");
        report_and_stop();
    end
endmodule // tb_queued_command_service
`default_nettype wire
